/* File: verilog/bcr_pkg.sv */
// Overview of operation
// - Direction low on writes, high otherwise.
// - Grant mode: direction pin becomes input.
// - Grant plus DRAM: strobes follow direction input.
// - DRAM disabled: direction input ignored in grant.
// - Ready ends cycle; next may follow.
// - Read data captured at edge after ready.
// - Internal ready after per-region programmed delay.
// - External ready overrides, ends cycle early.
// - Release bus after current operation completes.
`default_nettype none

package bcr_pkg;

   // ------------------------------------------------------------------
   // Widths and sizes.
   // ------------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int REGION_W = 2;
   localparam int NUM_REGIONS = 4;
   localparam int WAIT_W = 4;
   localparam int SYNC_W = DATA_W + 3;

   // ------------------------------------------------------------------
   // Positions inside the synchroniser vector.
   // ------------------------------------------------------------------
   localparam int SYNC_RDY_POS = DATA_W;
   localparam int SYNC_REQ_POS = DATA_W + 1;
   localparam int SYNC_DIR_POS = DATA_W + 2;

   // ------------------------------------------------------------------
   // Reset values and controller states.
   // ------------------------------------------------------------------
   localparam logic DIR_IDLE_VAL = 1'b1;
   localparam logic [WAIT_W-1:0] WAIT_RST = 4'h0;

   typedef enum logic [1:0]
   {
      BCR_IDLE = 2'b00,
      BCR_ACCESS = 2'b01,
      BCR_GRANT = 2'b10
   } bcr_state_type;

endpackage

`default_nettype wire

/* File: verilog/bcr_wg_if.sv */
`timescale 1ns/100ps
`default_nettype none

// Link between the cycle controller and the internal ready generator.
interface bcr_wg_if;
   import bcr_pkg::*;

   logic start;
   logic [REGION_W-1:0] region;
   logic end_cyc;
   logic int_rdy;

   modport ctl (output start, output region, output end_cyc, input int_rdy);
   modport gen (input start, input region, input end_cyc, output int_rdy);
endinterface

`default_nettype wire

/* File: verilog/bcr_wait_gen.sv */
`timescale 1ns/100ps
`default_nettype none

module bcr_wait_gen
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   bcr_wg_if.gen wg,
   input wire logic [bcr_pkg::NUM_REGIONS-1:0] wait_en_i,
   input wire logic [bcr_pkg::NUM_REGIONS*bcr_pkg::WAIT_W-1:0] wait_cnt_i
);
   import bcr_pkg::*;

   logic active_reg;
   logic [WAIT_W-1:0] cnt_reg;
   logic [WAIT_W-1:0] load_reg;
   logic [WAIT_W-1:0] elapsed_reg;
   logic [WAIT_W-1:0] sel_cnt;

   // ------------------------------------------------------------------
   // Delay counter.
   // ------------------------------------------------------------------

   // The delay is picked by the region of the cycle being started.
   assign sel_cnt = wait_cnt_i[wg.region*WAIT_W +: WAIT_W];

   // External end cancels count.
   // A new start wins over the end of the previous cycle so back to back cycles keep their delay.
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         active_reg <= 1'b0;
         cnt_reg <= WAIT_RST;
         load_reg <= WAIT_RST;
      end
      else if (wg.start)
      begin
         active_reg <= wait_en_i[wg.region];
         cnt_reg <= sel_cnt;
         load_reg <= sel_cnt;
      end
      else if (wg.end_cyc)
         active_reg <= 1'b0;
      else if (active_reg && cnt_reg != WAIT_RST)
         cnt_reg <= cnt_reg - 4'h1;
   end

   // Ready is raised once the count has run out; disabled regions rely on the pin alone.
   assign wg.int_rdy = active_reg && (cnt_reg == WAIT_RST);

   // Cycles spent in the current cycle, read only by the checks.
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         elapsed_reg <= WAIT_RST;
      else if (wg.start)
         elapsed_reg <= WAIT_RST;
      else if (active_reg && elapsed_reg != {WAIT_W{1'b1}})
         elapsed_reg <= elapsed_reg + 4'h1;
   end

   // ------------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------------
   a_delay_exact: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      wg.int_rdy |-> elapsed_reg == load_reg)
      else $error("internal ready at wrong delay");
   a_early_cancel: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      (wg.end_cyc && !wg.start) |=> !wg.int_rdy)
      else $error("internal ready after cycle ended");
   c_wait_hit: cover property (@(posedge sys_clk_i) disable iff (!nrst_i)
      wg.int_rdy && load_reg != WAIT_RST);

endmodule

`default_nettype wire

/* File: verilog/bcr_top.sv */
`timescale 1ns/100ps
`default_nettype none

module bcr_top
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic cyc_start_i,
   input wire logic cyc_write_i,
   input wire logic [bcr_pkg::REGION_W-1:0] cyc_region_i,
   input wire logic cyc_lock_i,
   input wire logic dram_en_i,
   input wire logic [bcr_pkg::NUM_REGIONS-1:0] wait_en_i,
   input wire logic [bcr_pkg::NUM_REGIONS*bcr_pkg::WAIT_W-1:0] wait_cnt_i,
   input wire logic ready_i,
   input wire logic external_master_request_i,
   input wire logic [bcr_pkg::DATA_W-1:0] data_i,
   input wire logic transfer_direction_i,
   output logic transfer_direction_o,
   output logic transfer_direction_oe_o,
   output logic dram_write_strobe_o,
   output logic dram_output_strobe_o,
   output logic grant_o,
   output logic busy_o,
   output logic pend_o,
   output logic done_o,
   output logic rd_valid_o,
   output logic [bcr_pkg::DATA_W-1:0] rd_data_o
);
   import bcr_pkg::*;

   bcr_state_type state_reg;
   bcr_state_type state_next;
   logic [SYNC_W-1:0] meta_reg;
   logic [SYNC_W-1:0] sync_reg;
   logic rdy_sync;
   logic req_sync;
   logic dir_sync;
   logic [DATA_W-1:0] data_sync;
   logic pend_reg;
   logic pend_wr_reg;
   logic [REGION_W-1:0] pend_region_reg;
   logic cyc_wr_reg;
   logic rdy_any;
   logic take;
   logic release_ok;

   bcr_wg_if wg ();

   // ------------------------------------------------------------------
   // Pin synchronisers.
   // ------------------------------------------------------------------

   // Ready sampled each edge.
   // Data share the ready path depth, so the capture stays aligned with the ready that ends the cycle.
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= {transfer_direction_i, external_master_request_i, ready_i, data_i};
         sync_reg <= meta_reg;
      end
   end

   assign rdy_sync = sync_reg[SYNC_RDY_POS];
   assign req_sync = sync_reg[SYNC_REQ_POS];
   assign dir_sync = sync_reg[SYNC_DIR_POS];
   assign data_sync = sync_reg[DATA_W-1:0];

   // ------------------------------------------------------------------
   // Request holding.
   // ------------------------------------------------------------------

   assign rdy_any = (state_reg == BCR_ACCESS) && (rdy_sync || wg.int_rdy);
   assign release_ok = req_sync && !cyc_lock_i;

   // One request waits here, so the core may queue the next cycle while one is on the bus.
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pend_reg <= 1'b0;
         pend_wr_reg <= 1'b0;
         pend_region_reg <= '0;
      end
      else if (cyc_start_i && !pend_reg)
      begin
         pend_reg <= 1'b1;
         pend_wr_reg <= cyc_write_i;
         pend_region_reg <= cyc_region_i;
      end
      else if (take)
         pend_reg <= 1'b0;
   end

   // ------------------------------------------------------------------
   // Cycle controller.
   // ------------------------------------------------------------------

   // Ready ends cycle, next follows.
   // A request from another master is honoured only between operations, never mid cycle.
   always_comb
   begin
      state_next = state_reg;
      take = 1'b0;
      case (state_reg)
         BCR_IDLE:
         begin
            if (release_ok)
               state_next = BCR_GRANT;
            else if (pend_reg)
            begin
               state_next = BCR_ACCESS;
               take = 1'b1;
            end
         end
         BCR_ACCESS:
         begin
            if (rdy_any)
            begin
               if (release_ok)
                  state_next = BCR_GRANT;
               else if (pend_reg)
                  take = 1'b1;
               else
                  state_next = BCR_IDLE;
            end
         end
         BCR_GRANT:
         begin
            if (!req_sync)
               state_next = BCR_IDLE;
         end
         default:
            state_next = BCR_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_reg <= BCR_IDLE;
         cyc_wr_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         if (take)
            cyc_wr_reg <= pend_wr_reg;
      end
   end

   // Control to the internal ready generator.
   assign wg.start = take;
   assign wg.region = pend_region_reg;
   assign wg.end_cyc = rdy_any;

   bcr_wait_gen u_wait_gen
   (
      .sys_clk_i (sys_clk_i),
      .nrst_i (nrst_i),
      .wg (wg.gen),
      .wait_en_i (wait_en_i),
      .wait_cnt_i (wait_cnt_i)
   );

   // ------------------------------------------------------------------
   // Direction pin and DRAM strobes.
   // ------------------------------------------------------------------

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         transfer_direction_o <= DIR_IDLE_VAL;
         transfer_direction_oe_o <= 1'b1;
      end
      else
      begin
         transfer_direction_oe_o <= (state_next != BCR_GRANT);
         if (state_next == BCR_ACCESS && (take ? pend_wr_reg : cyc_wr_reg))
            transfer_direction_o <= 1'b0;
         else
            transfer_direction_o <= DIR_IDLE_VAL;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         dram_write_strobe_o <= 1'b0;
         dram_output_strobe_o <= 1'b0;
      end
      else
      begin
         dram_write_strobe_o <= (state_next == BCR_GRANT) && dram_en_i && !dir_sync;
         dram_output_strobe_o <= (state_next == BCR_GRANT) && dram_en_i && dir_sync;
      end
   end

   // ------------------------------------------------------------------
   // Status and read data.
   // ------------------------------------------------------------------

   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         done_o <= 1'b0;
         rd_valid_o <= 1'b0;
         rd_data_o <= '0;
         grant_o <= 1'b0;
         busy_o <= 1'b0;
         pend_o <= 1'b0;
      end
      else
      begin
         done_o <= rdy_any;
         rd_valid_o <= rdy_any && !cyc_wr_reg;
         if (rdy_any && !cyc_wr_reg)
            rd_data_o <= data_sync;
         grant_o <= (state_next == BCR_GRANT);
         busy_o <= (state_next == BCR_ACCESS);
         pend_o <= (cyc_start_i && !pend_reg) || (pend_reg && !take);
      end
   end

   // ------------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);

   a_write_dir_low: assert property (busy_o && cyc_wr_reg |-> !transfer_direction_o && transfer_direction_oe_o)
      else $error("direction not low in write");
   a_idle_dir_high: assert property (!grant_o && !(busy_o && cyc_wr_reg) |-> transfer_direction_o)
      else $error("direction not high outside write");
   a_grant_no_drive: assert property (grant_o |-> !transfer_direction_oe_o)
      else $error("direction driven in grant mode");
   a_dram_strobe_src: assert property (dram_write_strobe_o |-> grant_o && $past(dram_en_i) && !$past(dir_sync))
      else $error("write strobe not from direction input");
   a_dram_off_quiet: assert property (!$past(dram_en_i) |-> !dram_write_strobe_o && !dram_output_strobe_o)
      else $error("strobe with DRAM disabled");
   a_back_to_back: assert property (rdy_any && pend_reg && !release_ok |=> busy_o && state_reg == BCR_ACCESS)
      else $error("next cycle not started at once");
   a_read_capture: assert property (rdy_any && !cyc_wr_reg |=> rd_valid_o && rd_data_o == $past(data_sync))
      else $error("read data not captured");
   a_ext_ends_early: assert property (state_reg == BCR_ACCESS && rdy_sync |=> done_o)
      else $error("external ready did not end cycle");
   a_release_after: assert property (rdy_any && release_ok |=> grant_o ##0 !busy_o)
      else $error("bus not released after cycle");
   a_hold_mid_cycle: assert property (state_reg == BCR_ACCESS && !rdy_any |=> state_reg == BCR_ACCESS)
      else $error("bus left mid cycle");
   a_ready_one_shot: assert property (done_o |-> $past(rdy_any))
      else $error("completion without ready");

   c_read_done: cover property (rd_valid_o);
   c_back_to_back: cover property (done_o ##[1:16] done_o);
   c_grant_dram: cover property (grant_o && dram_write_strobe_o);
   c_early_end: cover property (rdy_sync && !wg.int_rdy && state_reg == BCR_ACCESS);

endmodule

`default_nettype wire

/* File: verif/bcr_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// Memory responder on the far side of the bus cycle controller.
// ------------------------------------------------------------------
module bcr_mem_model
(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic busy_i,
   input wire logic done_i,
   input wire logic ext_en_i,
   input wire logic [3:0] dly_i,
   input wire logic [31:0] pattern_i,
   output logic ready_o,
   output logic [31:0] data_o
);
   logic [3:0] cnt_reg;
   logic sent_reg;

   // delayed single ready
   // Ready comes once per bus cycle, after the chosen access time has passed.
   // Off the ready cycle the bus shows the inverse, so a capture taken a cycle late is caught.
   always_ff @(posedge sys_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         ready_o <= 1'b0;
         data_o <= 32'h0000_0000;
         cnt_reg <= 4'h0;
         sent_reg <= 1'b0;
      end
      else if (done_i)
      begin
         ready_o <= 1'b0;
         data_o <= ~pattern_i;
         cnt_reg <= 4'h0;
         sent_reg <= 1'b0;
      end
      else if (busy_i && !sent_reg && ext_en_i && cnt_reg == dly_i)
      begin
         ready_o <= 1'b1;
         data_o <= pattern_i;
         sent_reg <= 1'b1;
      end
      else
      begin
         ready_o <= 1'b0;
         data_o <= ~pattern_i;
         if (busy_i && !sent_reg)
            cnt_reg <= cnt_reg + 4'h1;
      end
   end
endmodule

`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// Bench for the bus cycle controller.
// ------------------------------------------------------------------
module testbench;
   import bcr_pkg::*;

   logic sys_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic start = 1'b0, wr = 1'b0, lock = 1'b0, dram_en = 1'b0, req = 1'b0, alt_dir = 1'b1, ext_en = 1'b1;
   logic [1:0] region = 2'h0;
   logic [3:0] wen = 4'h0;
   logic [15:0] wcnt = 16'h0000;
   logic [3:0] dly = 4'h2;
   logic [31:0] pat = 32'h0000_0000;
   logic ready, dir_o, dir_oe, dws, dos, grant, busy, pend, done, rdv;
   logic [31:0] mdata, rdata;
   wire logic dir_wire;
   int n_fail = 0;
   int check_count = 0;
   int overlap = 0;

   // The alternate master drives the direction line only while the device lets go of it.
   assign dir_wire = dir_oe ? dir_o : alt_dir;

   initial
   begin
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end

   bcr_top uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cyc_start_i(start), .cyc_write_i(wr),
      .cyc_region_i(region), .cyc_lock_i(lock), .dram_en_i(dram_en), .wait_en_i(wen), .wait_cnt_i(wcnt),
      .ready_i(ready), .external_master_request_i(req), .data_i(mdata), .transfer_direction_i(dir_wire),
      .transfer_direction_o(dir_o), .transfer_direction_oe_o(dir_oe), .dram_write_strobe_o(dws),
      .dram_output_strobe_o(dos), .grant_o(grant), .busy_o(busy), .pend_o(pend), .done_o(done),
      .rd_valid_o(rdv), .rd_data_o(rdata));

   bcr_mem_model mem (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .busy_i(busy), .done_i(done), .ext_en_i(ext_en),
      .dly_i(dly), .pattern_i(pat), .ready_o(ready), .data_o(mdata));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out;
      $display("checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   function automatic logic sig(input int k);
      case (k)
         0: return busy;
         1: return done;
         2: return grant;
         default: return ~grant;
      endcase
   endfunction

   // Bounded wait at falling edges; also counts any cycle where grant and busy meet.
   task automatic wait_on(input int k, output int n);
      n = 0;
      while (sig(k) !== 1'b1)
      begin
         @(negedge sys_clk_i);
         n++;
         if (busy === 1'b1 && grant === 1'b1)
            overlap++;
         if (n > 100)
         begin
            n_fail++;
            close_out;
         end
      end
   endtask

   task automatic issue(input logic w, input logic [1:0] r, input logic [31:0] p);
      @(posedge sys_clk_i);
      start <= 1'b1;
      wr <= w;
      region <= r;
      pat <= p;
      @(posedge sys_clk_i);
      start <= 1'b0;
   endtask

   task automatic t_reset;
      @(negedge sys_clk_i);
      chk(dir_o, 1'b1);
      chk(dir_oe, 1'b1);
      chk({dws, dos, grant, busy, pend, done, rdv}, 7'h00);
      $display("test reset ended");
   endtask

   task automatic t_read;
      int n;
      int extra;
      issue(1'b0, 2'h0, 32'ha5c3_0f96);
      wait_on(1, n);
      chk(rdv, 1'b1);
      chk(rdata, 32'ha5c3_0f96);
      chk(dir_o, 1'b1);
      extra = 0;
      repeat (8)
      begin
         @(negedge sys_clk_i);
         if (done === 1'b1)
            extra++;
      end
      chk(32'(extra), 32'h0000_0000);
      $display("test read ended");
   endtask

   task automatic t_write;
      int n;
      issue(1'b1, 2'h1, 32'h1234_5678);
      wait_on(0, n);
      chk(dir_o, 1'b0);
      chk(dir_oe, 1'b1);
      wait_on(1, n);
      chk(rdv, 1'b0);
      $display("test write ended");
   endtask

   // A second request queued while the first runs must follow it with no loss.
   task automatic t_b2b;
      int n;
      int dones;
      issue(1'b0, 2'h0, 32'h0f0f_3c3c);
      wait_on(0, n);
      issue(1'b1, 2'h0, 32'h0f0f_3c3c);
      @(negedge sys_clk_i);
      chk(pend, 1'b1);
      dones = 0;
      repeat (40)
      begin
         @(negedge sys_clk_i);
         if (done === 1'b1)
            dones++;
      end
      chk(32'(dones), 32'h0000_0002);
      $display("test back to back ended");
   endtask

   // The internal generator alone, then an early external ready against a long count.
   task automatic t_int_over;
      int a;
      int b;
      int c;
      @(posedge sys_clk_i);
      ext_en <= 1'b0;
      wen <= 4'hc;
      wcnt <= 16'h6300;
      issue(1'b0, 2'h2, 32'h0000_0001);
      wait_on(1, a);
      issue(1'b0, 2'h3, 32'h0000_0002);
      wait_on(1, b);
      chk(32'(b - a), 32'h0000_0003);
      @(posedge sys_clk_i);
      ext_en <= 1'b1;
      dly <= 4'h1;
      wcnt <= 16'hf300;
      issue(1'b0, 2'h3, 32'h5a5a_0001);
      wait_on(1, c);
      // The early pin ready must beat even the shorter six cycle count, not only the long one.
      chk(c < b, 1'b1);
      chk(rdata, 32'h5a5a_0001);
      $display("test internal ready ended");
   endtask

   task automatic t_grant;
      int n;
      @(posedge sys_clk_i);
      dram_en <= 1'b1;
      alt_dir <= 1'b0;
      dly <= 4'h4;
      overlap = 0;
      issue(1'b0, 2'h0, 32'h0000_00ff);
      wait_on(0, n);
      // A locked operation keeps the bus across the request, so the queued read runs first.
      @(posedge sys_clk_i);
      req <= 1'b1;
      lock <= 1'b1;
      issue(1'b0, 2'h0, 32'h0000_00ff);
      wait_on(1, n);
      chk(grant, 1'b0);
      chk(busy, 1'b1);
      @(posedge sys_clk_i);
      lock <= 1'b0;
      wait_on(2, n);
      chk(done, 1'b1);
      chk(32'(overlap), 32'h0000_0000);
      chk(dir_oe, 1'b0);
      repeat (4) @(negedge sys_clk_i);
      chk({dws, dos}, 2'b10);
      @(posedge sys_clk_i);
      alt_dir <= 1'b1;
      repeat (5) @(negedge sys_clk_i);
      chk({dws, dos}, 2'b01);
      @(posedge sys_clk_i);
      dram_en <= 1'b0;
      alt_dir <= 1'b0;
      repeat (5) @(negedge sys_clk_i);
      chk({dws, dos}, 2'b00);
      @(posedge sys_clk_i);
      req <= 1'b0;
      wait_on(3, n);
      chk(dir_oe, 1'b1);
      chk(dir_o, 1'b1);
      $display("test grant ended");
   endtask

   initial
   begin
      t_reset;
      repeat (5) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      t_read;
      t_write;
      t_b2b;
      t_int_over;
      t_grant;
      close_out;
   end
endmodule

`default_nettype wire
